/* bench/dic_checker_assertions.sv */
module dic_checker (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input wire logic pulse_capable_input, // fifth line
  input wire logic [0:0] input_polarity_high_group, // fifth polarity
  input wire logic [29:0] input_function_select, // codes
  input wire logic [1:0] motor_group_select, // parameter
  input wire logic pulse_count_clear, // clear
  input wire logic [4:0] conditioned_level, // levels
  input wire logic [49:0] function_active, // functions
  input wire logic [1:0] active_motor_group, // group
  input wire logic [31:0] pulse_count, // count
  input wire logic pulse_edge // edge
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_group_override: assert property (
    (function_active[41] || function_active[42]) |=>
    active_motor_group == $past({function_active[42], function_active[41]})) else $error("group not from inputs");
  a_group_param: assert property (
    !(function_active[41] || function_active[42]) |=> active_motor_group == $past(motor_group_select))
    else $error("group not from parameter");
  a_count_step: assert property (
    pulse_edge && !$past(pulse_count_clear) |-> pulse_count == $past(pulse_count) + 32'h1) else $error("bad count");
  a_edge_single: assert property (pulse_edge |=> !pulse_edge) else $error("edge too long");
  a_count_clear: assert property (
    pulse_count_clear |=> pulse_count == {31'h0, pulse_edge}) else $error("clear ignored");
  a_pulse_walk: assert property (
    $rose(pulse_capable_input) && !input_polarity_high_group[0] |-> ##[1:4] pulse_edge) else $error("edge missed");
  a_func_none: assert property (!function_active[0]) else $error("code zero active");
  a_length_only: assert property (
    $past(input_function_select[29:24]) != 6'h1B |-> !function_active[27]) else $error("length on wrong line");
  a_length_fifth: assert property (
    conditioned_level[4] && input_function_select[29:24] == 6'h1B |=> function_active[27]) else $error("length lost");
  c_override: cover property (function_active[41] && function_active[42]);
  c_edge: cover property (pulse_edge);
  c_clear: cover property (pulse_count_clear ##1 pulse_count == 32'h0);
endmodule
bind dic_input_conditioning dic_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .pulse_capable_input(pulse_capable_input), .input_polarity_high_group(input_polarity_high_group),
  .input_function_select(input_function_select), .motor_group_select(motor_group_select),
  .pulse_count_clear(pulse_count_clear), .conditioned_level(conditioned_level), .function_active(function_active),
  .active_motor_group(active_motor_group), .pulse_count(pulse_count), .pulse_edge(pulse_edge));

/* bench/dic_contact_model.sv */
// open contact reads inactive, a shut one active
module dic_contact_model (
  input wire logic [4:0] closed, // contacts shut
  output logic term_one, // sense line 1
  output logic term_two, // sense line 2
  output logic term_three, // sense line 3
  output logic term_four, // sense line 4
  output logic term_five // sense line 5
);
  timeunit 1ns;
  timeprecision 1ns;
  assign {term_five, term_four, term_three, term_two, term_one} = closed;
endmodule

/* bench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] closed = 5'h00;
  logic [3:0] pol_lo = 4'h0;
  logic [0:0] pol_hi = 1'h0;
  logic [7:0] filt = 8'h00;
  logic [47:0] dly = 48'h0;
  logic [29:0] fsel = 30'h0;
  logic [1:0] grp = 2'h0;
  logic clr = 1'b0;
  logic t1, t2, t3, t4, t5, pedge;
  logic [4:0] lvl;
  logic [49:0] fact;
  logic [1:0] amg;
  logic [31:0] pcnt;
  int errors = 0;
  int cmp_count = 0;
  always #25 sys_clk = ~sys_clk;
  dic_contact_model i_sw (.closed(closed), .term_one(t1), .term_two(t2), .term_three(t3), .term_four(t4),
    .term_five(t5));
  dic_input_conditioning #(.DELAY_TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .digital_input_one(t1), .digital_input_two(t2), .digital_input_three(t3), .digital_input_four(t4),
    .pulse_capable_input(t5), .input_polarity_low_group(pol_lo), .input_polarity_high_group(pol_hi),
    .input_filter_time(filt), .input_delay_time(dly), .input_function_select(fsel), .motor_group_select(grp),
    .pulse_count_clear(clr), .conditioned_level(lvl), .function_active(fact), .active_motor_group(amg),
    .pulse_count(pcnt), .pulse_edge(pedge));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic drive(input int ch, input logic v);
    @(posedge sys_clk);
    closed[ch] <= v;
  endtask
  task automatic lat(input int ch, input logic v, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (lvl[ch] !== v && n < 400);
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_polarity;
    int n;
    for (int ch = 0; ch < 5; ch++) begin
      drive(ch, 1'b1);
      lat(ch, 1'b1, n);
      check(n >= 4 && n <= 5, 1'b1);
      check(lvl, 5'h01 << ch);
      drive(ch, 1'b0);
      lat(ch, 1'b0, n);
    end
    @(posedge sys_clk);
    {pol_hi, pol_lo} <= 5'h1A;
    closed <= 5'h03;
    idle(8);
    check(lvl, 5'h19);
    @(posedge sys_clk);
    {pol_hi, pol_lo} <= 5'h00;
    closed <= 5'h00;
    idle(8);
    $display("test polarity done");
  endtask
  task automatic t_filter;
    int n;
    @(posedge sys_clk);
    filt <= 8'h02;
    drive(3, 1'b1);
    idle(20);
    drive(3, 1'b0);
    lat(3, 1'b1, n);
    check(n, 400);
    drive(3, 1'b1);
    lat(3, 1'b1, n);
    check(n >= 26 && n <= 45, 1'b1);
    drive(3, 1'b0);
    lat(3, 1'b0, n);
    @(posedge sys_clk);
    filt <= 8'h00;
    $display("test filter done");
  endtask
  task automatic t_delay;
    int n, m;
    @(posedge sys_clk);
    dly <= 48'h0000_0000_0003;
    closed <= 5'h09;
    lat(3, 1'b1, n);
    check(n >= 4 && n <= 5, 1'b1);
    lat(0, 1'b1, m);
    check(n + m >= 14 && n + m <= 17, 1'b1);
    @(posedge sys_clk);
    closed <= 5'h00;
    idle(30);
    @(posedge sys_clk);
    dly <= 48'h0;
    $display("test delay done");
  endtask
  task automatic t_functions;
    @(posedge sys_clk);
    closed <= 5'h04;
    idle(6);
    for (int f = 1; f < 51; f++) begin
      @(posedge sys_clk);
      fsel <= 30'(f) << 12;
      idle(3);
      check(fact, (f == 27 || f == 50) ? 64'h0 : 64'h1 << f);
    end
    @(posedge sys_clk);
    closed <= 5'h00;
    fsel <= {6'h1B, 6'h1B, 6'h05, 6'h2A, 6'h29};
    grp <= 2'h3;
    idle(10);
    check(amg, 2'h3);
    drive(0, 1'b1);
    idle(8);
    check(amg, 2'h1);
    drive(1, 1'b1);
    drive(0, 1'b0);
    idle(8);
    check(amg, 2'h2);
    drive(1, 1'b0);
    drive(3, 1'b1);
    idle(8);
    check(amg, 2'h3);
    check(fact[27], 1'b0);
    drive(4, 1'b1);
    idle(8);
    check(fact[27], 1'b1);
    @(posedge sys_clk);
    closed <= 5'h00;
    idle(8);
    $display("test functions done");
  endtask
  task automatic t_pulse;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    idle(2);
    check(pcnt, 32'h0);
    for (int k = 0; k < 12; k++) begin
      drive(k < 6 ? 4 : 3, 1'b1);
      idle(3);
      drive(k < 6 ? 4 : 3, 1'b0);
      idle(3);
    end
    idle(4);
    check(pcnt, 32'h6);
    $display("test pulse done");
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    idle(2);
    t_polarity();
    t_filter();
    t_delay();
    t_functions();
    t_pulse();
    close_out();
  end
  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end
endmodule

/* hdl/dic_input_conditioning.sv */
module dic_input_conditioning #(
  parameter int unsigned DELAY_TICK_CYCLES = dic_pkg::DELAY_TICK_CYCLES_DEF
) (
  input wire logic sys_clk,                                    // 20 MHz clock
  input wire logic rst_n,                                      // async reset
  input wire logic digital_input_one,                          // high while shorted
  input wire logic digital_input_two,                          // high while shorted
  input wire logic digital_input_three,                        // high while shorted
  input wire logic digital_input_four,                         // high while shorted
  input wire logic pulse_capable_input,                        // high while shorted
  input wire logic [3:0] input_polarity_low_group,             // invert first four
  input wire logic [0:0] input_polarity_high_group,            // invert fifth
  input wire logic [7:0] input_filter_time,                    // filter, in us
  input wire logic [47:0] input_delay_time,                    // 3 x 16 bit, in ms
  input wire logic [29:0] input_function_select,               // 5 x 6 bit codes
  input wire logic [1:0] motor_group_select,                   // group parameter
  input wire logic pulse_count_clear,                          // zero the counter
  output logic [4:0] conditioned_level,                        // per channel level
  output logic [49:0] function_active,                         // per function level
  output logic [1:0] active_motor_group,                       // effective group
  output logic [31:0] pulse_count,                             // fifth channel rising edges
  output logic pulse_edge                                      // one cycle per rising edge
);

  // ----------------------------------------------------------------
  // shared time bases
  // ----------------------------------------------------------------
  logic [7:0] ftick_cnt_q;
  logic [15:0] dtick_cnt_q;
  logic ftick;
  logic dtick;
  logic [4:0] raw;
  logic [4:0] polarity;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] level;
  logic [4:0] filt_q;
  logic [4:0] cond_q;

  assign ftick = (ftick_cnt_q == 8'(dic_pkg::FILTER_TICK_CYCLES - 1));
  assign dtick = (dtick_cnt_q == 16'(DELAY_TICK_CYCLES - 1));

  // filter tick every microsecond
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ftick_cnt_q <= dic_pkg::FILTER_CNT_RESET;
    end else if (ftick) begin
      ftick_cnt_q <= dic_pkg::FILTER_CNT_RESET;
    end else begin
      ftick_cnt_q <= ftick_cnt_q + 8'h01;
    end
  end

  // delay tick every millisecond
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dtick_cnt_q <= dic_pkg::DELAY_CNT_RESET;
    end else if (dtick) begin
      dtick_cnt_q <= dic_pkg::DELAY_CNT_RESET;
    end else begin
      dtick_cnt_q <= dtick_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // per channel conditioning
  // ----------------------------------------------------------------
  // five terminals, each its own path
  assign raw = {pulse_capable_input, digital_input_four, digital_input_three,
                digital_input_two, digital_input_one};
  assign polarity = {input_polarity_high_group, input_polarity_low_group};

  // two-stage synchroniser on every terminal
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  // shorted reads one unless the polarity bit is set
  assign level = sync2_q ^ polarity;

  for (genvar ch = 0; ch < dic_pkg::NUM_CHANNELS; ch++) begin : g_chan
    logic [7:0] fcnt_q;

    // level must stay changed for the filter time before it is taken
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        fcnt_q <= dic_pkg::FILTER_CNT_RESET;
        filt_q[ch] <= 1'b0;
      end else if (level[ch] == filt_q[ch]) begin
        fcnt_q <= dic_pkg::FILTER_CNT_RESET;
      end else if (fcnt_q >= input_filter_time) begin
        fcnt_q <= dic_pkg::FILTER_CNT_RESET;
        filt_q[ch] <= level[ch];
      end else if (ftick) begin
        fcnt_q <= fcnt_q + 8'h01;
      end
    end

    if (ch < dic_pkg::DELAY_CHANNELS) begin : g_delay
      logic [15:0] dcnt_q;
      logic [15:0] dly_time;

      assign dly_time = input_delay_time[ch*dic_pkg::DELAY_WIDTH +: dic_pkg::DELAY_WIDTH];

      // both edges held back by the delay time, restarting on a bounce
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          dcnt_q <= dic_pkg::DELAY_CNT_RESET;
          cond_q[ch] <= 1'b0;
        end else if (filt_q[ch] == cond_q[ch]) begin
          dcnt_q <= dic_pkg::DELAY_CNT_RESET;
        end else if (dcnt_q >= dly_time) begin
          dcnt_q <= dic_pkg::DELAY_CNT_RESET;
          cond_q[ch] <= filt_q[ch];
        end else if (dtick) begin
          dcnt_q <= dcnt_q + 16'h0001;
        end
      end
    end else begin : g_nodelay
      // no delay stage on the remaining channels
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cond_q[ch] <= 1'b0;
        end else begin
          cond_q[ch] <= filt_q[ch];
        end
      end
    end
  end

  assign conditioned_level = cond_q;

  // ----------------------------------------------------------------
  // function mapping
  // ----------------------------------------------------------------
  logic [49:0] func_d;
  logic [49:0] func_q;

  // each active channel drives the function its selector names; length count only from the fifth
  always_comb begin
    logic [5:0] code;
    code = dic_pkg::FUNC_NONE;
    func_d = 50'h0;
    for (int ch = 0; ch < dic_pkg::NUM_CHANNELS; ch++) begin
      code = input_function_select[ch*dic_pkg::FUNC_WIDTH +: dic_pkg::FUNC_WIDTH];
      if (code >= dic_pkg::FUNC_LIMIT) begin
        code = dic_pkg::FUNC_NONE;
      end else if (code == dic_pkg::FUNC_LENGTH_COUNT && ch != dic_pkg::PULSE_CHANNEL) begin
        code = dic_pkg::FUNC_NONE;
      end
      if (cond_q[ch] && code != dic_pkg::FUNC_NONE) begin
        func_d[code] = 1'b1;
      end
    end
  end

  // registered function levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= 50'h0;
    end else begin
      func_q <= func_d;
    end
  end

  assign function_active = func_q;

  // ----------------------------------------------------------------
  // motor group selection
  // ----------------------------------------------------------------
  logic [1:0] group_q;
  logic sel_low;
  logic sel_high;

  assign sel_low = func_q[dic_pkg::FUNC_GROUP_SEL_LOW];
  assign sel_high = func_q[dic_pkg::FUNC_GROUP_SEL_HIGH];

  // terminal selection wins over the parameter while either is on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_q <= dic_pkg::GROUP_RESET;
    end else if (sel_low || sel_high) begin
      group_q <= {sel_high, sel_low};
    end else begin
      group_q <= motor_group_select;
    end
  end

  assign active_motor_group = group_q;

  // ----------------------------------------------------------------
  // high-speed pulse counting
  // ----------------------------------------------------------------
  logic pulse_prev_q;
  logic pulse_rise;
  logic edge_q;
  logic [31:0] count_q;
  logic [2:0] arm_q;

  // unfiltered path, so fast pulses are not swallowed by the filter;
  // held off until synchroniser and previous level carry real samples,
  // so an input already active at reset release is not counted
  assign pulse_rise = level[dic_pkg::PULSE_CHANNEL] & ~pulse_prev_q & arm_q[2];

  // edge detect and count; an edge in the clear cycle is kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_prev_q <= 1'b0;
      edge_q <= 1'b0;
      arm_q <= 3'h0;
      count_q <= dic_pkg::COUNT_RESET;
    end else begin
      arm_q <= {arm_q[1:0], 1'b1};
      pulse_prev_q <= level[dic_pkg::PULSE_CHANNEL];
      edge_q <= pulse_rise;
      if (pulse_count_clear) begin
        count_q <= pulse_rise ? 32'h0000_0001 : dic_pkg::COUNT_RESET;
      end else if (pulse_rise) begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  assign pulse_count = count_q;
  assign pulse_edge = edge_q;

endmodule

/* inc/dic_pkg.sv */
package dic_pkg;

  // ----------------------------------------------------------------
  // channel layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS = 5;           // terminal count
  localparam int unsigned DELAY_CHANNELS = 3;         // first three have a delay stage
  localparam int unsigned PULSE_CHANNEL = 4;          // fifth terminal, zero based
  localparam int unsigned LOW_GROUP_WIDTH = 4;        // polarity bits, first four terminals
  localparam int unsigned HIGH_GROUP_WIDTH = 1;       // polarity bits, fifth terminal

  // ----------------------------------------------------------------
  // input functions
  // ----------------------------------------------------------------
  localparam int unsigned FUNC_WIDTH = 6;
  localparam int unsigned NUM_FUNCTIONS = 50;
  localparam logic [5:0] FUNC_NONE = 6'h00;           // code 0 drives nothing
  localparam logic [5:0] FUNC_LENGTH_COUNT = 6'h1B;   // 27
  localparam logic [5:0] FUNC_GROUP_SEL_LOW = 6'h29;  // 41
  localparam logic [5:0] FUNC_GROUP_SEL_HIGH = 6'h2A; // 42
  localparam logic [5:0] FUNC_LIMIT = 6'h32;          // 50, first illegal code

  // ----------------------------------------------------------------
  // field widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FILTER_WIDTH = 8;
  localparam int unsigned DELAY_WIDTH = 16;
  localparam int unsigned GROUP_WIDTH = 2;
  localparam int unsigned COUNT_WIDTH = 32;
  localparam int unsigned DLY_TICK_WIDTH = 16;
  localparam logic [7:0] FILTER_CNT_RESET = 8'h00;
  localparam logic [15:0] DELAY_CNT_RESET = 16'h0000;
  localparam logic [1:0] GROUP_RESET = 2'h0;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FILTER_TICK_NS = 1000;      // filter unit 1 us
  localparam int unsigned DELAY_TICK_NS = 1000000;    // delay unit 1 ms
  localparam int unsigned FILTER_TICK_CYCLES = FILTER_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DELAY_TICK_CYCLES_DEF = DELAY_TICK_NS / CLK_PERIOD_NS;

endpackage
